// ---- nvsc_host.sv ----
// Host controller driving the nonvolatile SRAM's asynchronous pins
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Write: select, write low; address held stable
// - Host keeps output enable high when writing
// - Keep write disabled until host leaves reset
// - Disable autostore when no capacitor fitted; host does so only on an NVSC_CMD_AS_OFF request
// - Six read sequence ending 0x8FC0 stores
module nvsc_host
   import nvsc_pkg::*;
#(
   parameter int ADDR_WIDTH = ADDR_W,
   parameter int DATA_WIDTH = DATA_W
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire nvsc_op_e req_op,
   input wire nvsc_cmd_e req_cmd,
   input wire logic [ADDR_WIDTH-1:0] req_addr,
   input wire logic [DATA_WIDTH-1:0] req_wdata,
   input wire logic [1:0] req_lanes,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_WIDTH-1:0] rsp_rdata,
   output logic [ADDR_WIDTH-1:0] mem_addr,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic upper_byte_enable_n,
   output logic lower_byte_enable_n,
   input wire logic [DATA_WIDTH-1:0] dq_in,
   output logic [DATA_WIDTH-1:0] dq_out,
   output logic dq_oe,
   input wire logic store_busy_n_in,
   output logic store_busy_n_out,
   output logic store_busy_n_oe
);
   localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(ADDR_ACCESS_CYC);
   localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(WRITE_PULSE_CYC);
   localparam logic [CNT_W-1:0] DLY_CYC = CNT_W'(STORE_DELAY_CYC);
   localparam logic [CNT_W-1:0] HO_CYC = CNT_W'(HOLDOFF_CYC);
   localparam logic [2:0] SEQ_LAST = 3'(SEQ_LEN - 1);

   nvsc_sync_if busy_if ();
   nvsc_state_e state_q;
   nvsc_op_e op_q;
   nvsc_cmd_e cmd_q;
   logic [CNT_W-1:0] cnt_q;
   logic [2:0] seq_q;
   logic [ADDR_WIDTH-1:0] addr_q;
   logic [DATA_WIDTH-1:0] wdata_q;
   logic [1:0] lanes_q;
   logic [15:0] seq_addr;

   nvsc_sync u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin_in(store_busy_n_in),
      .sync(busy_if.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequence address of the current command step
   always_comb begin
      case (seq_q)
         3'h0: seq_addr = SEQ_A0;
         3'h1: seq_addr = SEQ_A1;
         3'h2: seq_addr = SEQ_A2;
         3'h3: seq_addr = SEQ_A3;
         3'h4: seq_addr = SEQ_A4;
         default: begin
            case (cmd_q)
               NVSC_CMD_STORE: seq_addr = SEQ_STORE;
               NVSC_CMD_RECALL: seq_addr = SEQ_RECALL;
               NVSC_CMD_AS_OFF: seq_addr = SEQ_AS_OFF;
               default: seq_addr = SEQ_AS_ON;
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request capture and sequencing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= NVSC_IDLE;
         op_q <= NVSC_OP_READ;
         cmd_q <= NVSC_CMD_STORE;
         cnt_q <= '0;
         seq_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         lanes_q <= 2'h0;
      end else if (clk_en) begin
         case (state_q)
            NVSC_IDLE: begin
               // Busy low means store, recall or external request
               if (req_valid && !busy_if.busy_low) begin
                  op_q <= req_op;
                  cmd_q <= req_cmd;
                  addr_q <= req_addr;
                  wdata_q <= req_wdata;
                  lanes_q <= req_lanes;
                  seq_q <= '0;
                  cnt_q <= '0;
                  state_q <= (req_op == NVSC_OP_HWSTORE) ? NVSC_STROBE
                                                         : NVSC_SETUP;
               end
            end
            NVSC_SETUP: begin
               // Address settles one cycle before any strobe
               cnt_q <= '0;
               state_q <= NVSC_STROBE;
            end
            NVSC_STROBE: begin
               cnt_q <= cnt_q + 1'b1;
               if (op_q == NVSC_OP_HWSTORE) begin
                  if (cnt_q >= DLY_CYC) begin
                     cnt_q <= '0;
                     state_q <= NVSC_REL;
                  end
               end else if (cnt_q + 1'b1 >= ((op_q == NVSC_OP_WRITE)
                                             ? WR_CYC : RD_CYC)) begin
                  state_q <= NVSC_REL;
               end
            end
            NVSC_REL: begin
               cnt_q <= '0;
               if (op_q == NVSC_OP_CMD && seq_q != SEQ_LAST) begin
                  seq_q <= seq_q + 3'h1;
                  state_q <= NVSC_SETUP;
               end else if (op_q == NVSC_OP_CMD
                            && cmd_q inside {NVSC_CMD_STORE,
                                             NVSC_CMD_RECALL}) begin
                  state_q <= NVSC_BUSYWAIT;
               end else if (op_q == NVSC_OP_HWSTORE) begin
                  state_q <= NVSC_BUSYWAIT;
               end else begin
                  state_q <= NVSC_DONE;
               end
            end
            NVSC_BUSYWAIT: begin
               // Wait for the device to let the line rise again
               if (!busy_if.busy_low) begin
                  cnt_q <= '0;
                  state_q <= NVSC_HOLDOFF;
               end
            end
            NVSC_HOLDOFF: begin
               cnt_q <= cnt_q + 1'b1;
               if (busy_if.busy_low) begin
                  cnt_q <= '0;
               end else if (cnt_q + 1'b1 >= HO_CYC) begin
                  state_q <= NVSC_DONE;
               end
            end
            NVSC_DONE: begin
               state_q <= NVSC_IDLE;
            end
            default: state_q <= NVSC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory pins, all registered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_addr <= '0;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_en_n <= 1'b1;
         upper_byte_enable_n <= 1'b1;
         lower_byte_enable_n <= 1'b1;
         dq_out <= '0;
         dq_oe <= 1'b0;
      end else if (clk_en) begin
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_en_n <= 1'b1;
         dq_oe <= 1'b0;
         if (state_q == NVSC_SETUP) begin
            mem_addr <= (op_q == NVSC_OP_CMD)
                        ? ADDR_WIDTH'(seq_addr) : addr_q;
            upper_byte_enable_n <= (op_q == NVSC_OP_CMD) ? 1'b0
                                                         : ~lanes_q[1];
            lower_byte_enable_n <= (op_q == NVSC_OP_CMD) ? 1'b0
                                                         : ~lanes_q[0];
            dq_out <= wdata_q;
         end
         if (state_q == NVSC_STROBE && op_q != NVSC_OP_HWSTORE
             && !(cnt_q + 1'b1 >= ((op_q == NVSC_OP_WRITE)
                                    ? WR_CYC : RD_CYC))) begin
            chip_sel_n <= 1'b0;
            if (op_q == NVSC_OP_WRITE) begin
               write_en_n <= 1'b0;
               dq_oe <= 1'b1;
            end else begin
               out_en_n <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Store-busy pin: open drain, only ever pulled low by the host
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         store_busy_n_out <= 1'b0;
         store_busy_n_oe <= 1'b0;
      end else if (clk_en) begin
         store_busy_n_out <= 1'b0;
         // Released once request delay passes; device then holds it only if written since the last store or recall
         store_busy_n_oe <= state_q == NVSC_STROBE
                            && op_q == NVSC_OP_HWSTORE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Answer side
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else if (clk_en) begin
         req_ready <= state_q == NVSC_DONE
                      || (state_q == NVSC_IDLE && !req_valid
                          && !busy_if.busy_low);
         rsp_valid <= state_q == NVSC_DONE;
         // Sampled on the last strobe cycle, after access time
         if (state_q == NVSC_STROBE && op_q == NVSC_OP_READ
             && cnt_q + 1'b1 == RD_CYC) begin
            rsp_rdata <= dq_in;
         end
      end
   end
endmodule

// ---- nvsc_pkg.sv ----
// Package: pin timing, software sequence addresses and states for the host
package nvsc_pkg;
   localparam int CLK_MHZ = 100;
   // Times in ns as used by the host; cycles derived, least times rounded up
   localparam int ADDR_ACCESS_NS = 25;
   localparam int WRITE_PULSE_NS = 25;
   localparam int WRITE_TURNOFF_NS = 15;
   localparam int STORE_DELAY_NS = 25;
   localparam int HOLDOFF_NS = 20;
   localparam int ADDR_ACCESS_CYC = (ADDR_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_TURNOFF_CYC =
      (WRITE_TURNOFF_NS * CLK_MHZ + 999) / 1000;
   localparam int STORE_DELAY_CYC = (STORE_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLDOFF_CYC = (HOLDOFF_NS * CLK_MHZ + 999) / 1000;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;
   localparam int SEQ_LEN = 6;
   localparam logic [15:0] SEQ_A0 = 16'h4E38;
   localparam logic [15:0] SEQ_A1 = 16'hB1C7;
   localparam logic [15:0] SEQ_A2 = 16'h83E0;
   localparam logic [15:0] SEQ_A3 = 16'h7C1F;
   localparam logic [15:0] SEQ_A4 = 16'h703F;
   localparam logic [15:0] SEQ_STORE = 16'h8FC0;
   localparam logic [15:0] SEQ_RECALL = 16'h4C63;
   localparam logic [15:0] SEQ_AS_OFF = 16'h8B45;
   localparam logic [15:0] SEQ_AS_ON = 16'h4B46;
   typedef enum logic [1:0] {
      NVSC_OP_READ = 2'h0,
      NVSC_OP_WRITE = 2'h1,
      NVSC_OP_CMD = 2'h2,
      NVSC_OP_HWSTORE = 2'h3
   } nvsc_op_e;
   typedef enum logic [1:0] {
      NVSC_CMD_STORE = 2'h0,
      NVSC_CMD_RECALL = 2'h1,
      NVSC_CMD_AS_OFF = 2'h2,
      NVSC_CMD_AS_ON = 2'h3
   } nvsc_cmd_e;
   typedef enum logic [6:0] {
      NVSC_IDLE = 7'h01,
      NVSC_SETUP = 7'h02,
      NVSC_STROBE = 7'h04,
      NVSC_REL = 7'h08,
      NVSC_BUSYWAIT = 7'h10,
      NVSC_HOLDOFF = 7'h20,
      NVSC_DONE = 7'h40
   } nvsc_state_e;
endpackage

// ---- nvsc_sync_if.sv ----
// Interface: synchronised busy-line level between host modules
`timescale 1ns/1ps
interface nvsc_sync_if;
   logic busy_low;
   modport src (output busy_low);
   modport dst (input busy_low);
endinterface

// ---- nvsc_sync.sv ----
// Two-flop synchroniser for the store-busy pin level
`timescale 1ns/1ps
module nvsc_sync (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic pin_in,
   nvsc_sync_if.src sync
);
   logic meta_q;
   logic stable_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= 1'b1;
         stable_q <= 1'b1;
      end else if (clk_en) begin
         meta_q <= pin_in;
         stable_q <= meta_q;
      end
   end
   assign sync.busy_low = ~stable_q;
endmodule

// ---- nvsc_host_monitor.sv ----
// Checker: pin protocol of the host controller
`timescale 1ns/1ps
module nvsc_host_monitor
   import nvsc_pkg::*;
#(parameter int ADDR_WIDTH = ADDR_W) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [ADDR_WIDTH-1:0] mem_addr,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic dq_oe,
   input wire logic store_busy_n_in,
   input wire logic store_busy_n_out,
   input wire logic store_busy_n_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_wr_oe_high: assert property (!write_en_n |-> out_en_n)
      else $error("oe low in write");
   chk_wr_addr_hold: assert property (!write_en_n && !$past(write_en_n)
      |-> $stable(mem_addr)) else $error("addr moved in write");
   chk_rd_no_drive: assert property (!out_en_n |-> !dq_oe && write_en_n)
      else $error("host drives in read");
   chk_rd_hold: assert property ($fell(out_en_n) |-> !chip_sel_n
      ##1 (!out_en_n && !chip_sel_n && $stable(mem_addr)))
      else $error("read too short");
   chk_pull_low: assert property (store_busy_n_oe |-> !store_busy_n_out)
      else $error("busy driven high");
   chk_pull_len: assert property ($rose(store_busy_n_oe) |->
      store_busy_n_oe[*3] ##[1:3] !store_busy_n_oe) else $error("pull length");
   // Eight cycles covers sync delay plus a strobe already running
   chk_busy_block: assert property ((!store_busy_n_in)[*8] |->
      chip_sel_n) else $error("access while busy");
   chk_post_busy: assert property ($rose(store_busy_n_in) |->
      chip_sel_n[*3]) else $error("access in holdoff");
endmodule
bind nvsc_host nvsc_host_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
   .clk_sys(clk_sys),
   .reset_n(reset_n),
   .mem_addr(mem_addr),
   .chip_sel_n(chip_sel_n),
   .out_en_n(out_en_n),
   .write_en_n(write_en_n),
   .dq_oe(dq_oe),
   .store_busy_n_in(store_busy_n_in),
   .store_busy_n_out(store_busy_n_out),
   .store_busy_n_oe(store_busy_n_oe)
);

// ---- nvsc_dev.sv ----
// Device model: SRAM array, store triggers and busy pin
`timescale 1ns/1ps
module nvsc_dev
   import nvsc_pkg::*;
#(parameter int ST_CYC = 20) (
   input wire logic clk_sys,
   input wire logic vcc_low,
   input wire logic [ADDR_W-1:0] a,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic ub_n,
   input wire logic lb_n,
   input wire logic [DATA_W-1:0] d,
   input wire logic pull,
   output logic [DATA_W-1:0] q,
   output logic pin
);
   localparam int HO = 2;
   localparam logic [15:0] SQ [6] =
      '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_STORE};
   bit [15:0] mem [0:262143];
   // Nonvolatile copy, filled by every store, read back by every recall
   bit [15:0] nv [0:262143];
   logic latch_q = 1'b0;
   logic wr_q = 1'b0;
   logic auto_q = 1'b1;
   logic tog_q = 1'b0;
   logic rd_q = 1'b0;
   logic vl_q = 1'b0;
   logic [7:0] cnt_q = 8'h00;
   logic [2:0] st_q = 3'h0;
   logic [2:0] hw_q = 3'h0;
   logic [15:0] ad_q = 16'h0000;
   logic rd, wr, go, sw;
   // Pull-up wins once nobody pulls; access stays blocked for HO more
   assign pin = !(pull || cnt_q > 8'(HO));
   assign rd = !ce_n && !oe_n && we_n && pin && cnt_q == 0;
   // A write already under way may finish inside the request delay
   assign wr = !ce_n && !we_n
      && ((pin && cnt_q == 0) || wr_q);
   assign go = (hw_q == 3'h2 && latch_q)
      || (vcc_low && !vl_q && auto_q && latch_q);
   assign sw = rd_q && !rd && st_q == 3'h5
      && (ad_q == SEQ_STORE || ad_q == SEQ_RECALL);
   // Undriven lanes toggle so a stale value never reads as data
   always_comb begin
      q = {16{tog_q}};
      if (rd && !ub_n) q[15:8] = mem[a][15:8];
      if (rd && !lb_n) q[7:0] = mem[a][7:0];
   end
   always @(posedge clk_sys) begin
      tog_q <= ~tog_q;
      rd_q <= rd;
      wr_q <= wr;
      vl_q <= vcc_low;
      if (rd) ad_q <= a[15:0];
      if (!pull) hw_q <= 3'h0;
      else if (hw_q != 3'h3 && cnt_q == 0) hw_q <= hw_q + 3'h1;
      if (cnt_q != 0) cnt_q <= cnt_q - 8'h01;
      if (wr) begin
         if (!ub_n) mem[a][15:8] <= d[15:8];
         if (!lb_n) mem[a][7:0] <= d[7:0];
         latch_q <= 1'b1;
         st_q <= 3'h0;
      end
      if (rd_q && !rd) begin
         st_q <= ad_q == SQ[st_q] ? st_q + 3'h1 : 3'(ad_q == SEQ_A0);
         if (st_q == 3'h5) begin
            st_q <= 3'h0;
            if (ad_q == SEQ_AS_OFF) auto_q <= 1'b0;
            if (ad_q == SEQ_AS_ON) auto_q <= 1'b1;
         end
      end
      if (go || sw) begin
         cnt_q <= 8'(ST_CYC);
         latch_q <= 1'b0;
         for (int i = 0; i < 262144; i++) begin
            if (sw && ad_q == SEQ_RECALL) begin
               mem[i] <= nv[i];
            end else begin
               nv[i] <= mem[i];
            end
         end
      end
      // Supply back above threshold: recall, busy held meanwhile
      if (vl_q && !vcc_low) begin
         cnt_q <= 8'(ST_CYC);
         latch_q <= 1'b0;
         for (int i = 0; i < 262144; i++) mem[i] <= nv[i];
      end
   end
endmodule

// ---- testbench.sv ----
// Testbench: host controller against the device model
`timescale 1ns/1ps
module testbench;
   import nvsc_pkg::*;
   localparam int ST = 20;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic vcc_low = 1'b0;
   nvsc_op_e req_op = NVSC_OP_READ;
   nvsc_cmd_e req_cmd = NVSC_CMD_STORE;
   logic [17:0] req_addr = 18'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic [1:0] req_lanes = 2'h3;
   logic [17:0] mem_addr;
   logic [15:0] rsp_rdata, dq_out, q, rdat;
   logic req_ready, rsp_valid, ce_n, oe_n, we_n, ub_n, lb_n, dq_oe;
   logic pin, bout, boe;
   int n_errors = 0;
   int comparisons = 0;
   int lowcnt = 0;
   int lc;
   logic rdy;
   nvsc_host u_nvsc_host (.clk_sys, .reset_n, .clk_en(1'b1), .req_valid,
      .req_op, .req_cmd, .req_addr, .req_wdata, .req_lanes, .req_ready,
      .rsp_valid, .rsp_rdata, .mem_addr, .chip_sel_n(ce_n), .out_en_n(oe_n),
      .write_en_n(we_n), .upper_byte_enable_n(ub_n),
      .lower_byte_enable_n(lb_n), .dq_in(dq_oe ? dq_out : q), .dq_out,
      .dq_oe, .store_busy_n_in(pin), .store_busy_n_out(bout),
      .store_busy_n_oe(boe));
   nvsc_dev #(.ST_CYC(ST)) u_nvsc_dev (.clk_sys, .vcc_low, .a(mem_addr),
      .ce_n, .oe_n, .we_n, .ub_n, .lb_n, .d(dq_out), .pull(boe && !bout),
      .q, .pin);
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (!pin) lowcnt <= lowcnt + 1;
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Request dropped once it shows on the pins, so IDLE never retakes it
   task automatic req(input nvsc_op_e op, input logic [17:0] ad,
         input logic [15:0] wd = 16'h0000, input logic [1:0] ln = 2'h3,
         input nvsc_cmd_e cm = NVSC_CMD_STORE);
      int n, l0;
      @(posedge clk_sys);
      l0 = lowcnt;
      req_op <= op;
      req_cmd <= cm;
      req_addr <= ad;
      req_wdata <= wd;
      req_lanes <= ln;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (ce_n === 1'b0 || boe === 1'b1) req_valid <= 1'b0;
      end while (rsp_valid !== 1'b1 && n < 3000);
      if (rsp_valid !== 1'b1) begin
         n_errors++;
         finish_test();
      end
      rdat = rsp_rdata;
      rdy = req_ready;
      lc = lowcnt - l0;
   endtask
   task automatic t_rw();
      req(NVSC_OP_WRITE, 18'h25A5A, 16'hA55A);
      check(16'(rdy), 16'h0001);
      req(NVSC_OP_WRITE, 18'h3FFFF, 16'h0FF0);
      req(NVSC_OP_READ, 18'h25A5A);
      check(rdat, 16'hA55A);
      req(NVSC_OP_WRITE, 18'h25A5A, 16'h12C3, 2'h1);
      req(NVSC_OP_READ, 18'h25A5A, 16'h0000, 2'h2);
      check({rdat[15:8], 8'h00}, 16'hA500);
      req(NVSC_OP_READ, 18'h25A5A);
      check(rdat, 16'hA5C3);
      req(NVSC_OP_READ, 18'h3FFFF);
      check(rdat, 16'h0FF0);
      $display("t_rw done");
   endtask
   task automatic t_store();
      req(NVSC_OP_CMD, 18'h00000);
      check(16'(lc >= ST - 2), 16'h0001);
      req(NVSC_OP_HWSTORE, 18'h00000);
      check(16'(lc < 8), 16'h0001);
      req(NVSC_OP_WRITE, 18'h00100, 16'h00C3);
      req(NVSC_OP_HWSTORE, 18'h00000);
      check(16'(lc >= ST - 2), 16'h0001);
      req(NVSC_OP_CMD, 18'h00000);
      check(16'(lc >= ST - 2), 16'h0001);
      $display("t_store done");
   endtask
   task automatic t_auto();
      for (int i = 0; i < 2; i++) begin
         req(NVSC_OP_WRITE, 18'h00200, 16'h5AA5 ^ 16'(i));
         vcc_low <= 1'b1;
         repeat (3) @(posedge clk_sys);
         vcc_low <= 1'b0;
         // Recall starts on recovery; give the host time to see busy
         repeat (3) @(posedge clk_sys);
         req(NVSC_OP_READ, 18'h00200);
         // Second pass has autostore off, so recall returns the first word
         check(rdat, 16'h5AA5);
         check(16'(lc > 12), 16'h0001);
         req(NVSC_OP_CMD, 18'h00000, 16'h0000, 2'h3, NVSC_CMD_AS_OFF);
      end
      req(NVSC_OP_CMD, 18'h00000, 16'h0000, 2'h3, NVSC_CMD_AS_ON);
      req(NVSC_OP_CMD, 18'h00000, 16'h0000, 2'h3, NVSC_CMD_RECALL);
      req(NVSC_OP_READ, 18'h00200);
      check(rdat, 16'h5AA5);
      $display("t_auto done");
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_rw();
      t_store();
      t_auto();
      finish_test();
   end
endmodule
